// *** rtl/sesc_pkg.sv ***
package sesc_pkg;
	// Command codes presented on the command port
	typedef enum logic [3:0] {
		SESC_CMD_NONE = 4'h0,
		SESC_CMD_ESE_WR = 4'h1,
		SESC_CMD_ESE_RD = 4'h2,
		SESC_CMD_ESR_RD = 4'h3,
		SESC_CMD_OPC = 4'h4,
		SESC_CMD_OPC_RD = 4'h5,
		SESC_CMD_PSC_WR = 4'h6,
		SESC_CMD_PSC_RD = 4'h7,
		SESC_CMD_CLS = 4'h8,
		SESC_CMD_SRE_WR = 4'h9,
		SESC_CMD_SRE_RD = 4'hA
	} sesc_cmd_t;
	// Enable bits that carry a function
	localparam logic [7:0] SESC_ESE_USED = 8'hBD;
	// Status byte enable bits that carry a function
	localparam logic [7:0] SESC_SRE_USED = 8'h38;
	// Operation-complete bit position
	localparam int SESC_OPC_BIT = 0;
	// Character placed for operation-complete query
	localparam logic [7:0] SESC_CHAR_ONE = 8'h31;
	// Reset values
	localparam logic [7:0] SESC_ZERO8 = 8'h00;
	// Request carrier
	typedef struct packed {
		sesc_cmd_t cmd;
		logic [7:0] arg;
	} sesc_req_t;
	// Answer carrier
	typedef struct packed {
		logic is_char;
		logic [7:0] value;
	} sesc_rsp_t;
endpackage

// *** rtl/sesc_nv_store.sv ***
`timescale 1ns/100ps
// Non-volatile backing: holds the power-on clear flag; saved enable inputs are unused here.
// The store itself sits outside; this keeps the restored flag and
// the write-back strobe, so the live copy survives a power cycle.
module sesc_nv_store
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_nv_psc,
	input wire logic [7:0] i_nv_ese,
	input wire logic [7:0] i_nv_sre,
	input wire logic i_load,
	input wire logic i_psc_wr,
	input wire logic i_psc_val,
	output logic o_psc,
	output logic o_restore,
	output logic o_nv_we
);
	// Live copy of the power-on clear flag
	logic psc_ff;
	// Set for one cycle while the stored image is adopted
	logic restore_ff;
	// Write-back strobe toward the non-volatile store
	logic we_ff;

	// Adopt stored flag after reset release, track writes after
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			psc_ff <= 1'b0;
		else if (i_load)
			psc_ff <= i_nv_psc;
		else if (i_psc_wr)
			psc_ff <= i_psc_val;
	end

	// Restore pulse marks the power-up decision cycle
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			restore_ff <= 1'b0;
		else
			restore_ff <= i_load;
	end

	// Every setting change is written back so it outlives power loss
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			we_ff <= 1'b0;
		else
			we_ff <= i_psc_wr;
	end

	assign o_psc = psc_ff;
	assign o_restore = restore_ff;
	assign o_nv_we = we_ff;
endmodule

// *** rtl/sesc_top.sv ***
`timescale 1ns/100ps
// Common status command executor: event enable, event register,
// operation complete, power-on clear and clear-status.
module sesc_top
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire sesc_pkg::sesc_req_t i_req,
	input wire logic [7:0] i_event_set,
	input wire logic i_nv_psc,
	input wire logic [7:0] i_nv_ese,
	input wire logic [7:0] i_nv_sre,
	output logic o_rsp_valid,
	output sesc_pkg::sesc_rsp_t o_rsp,
	output logic o_nv_we,
	output logic o_nv_psc,
	output logic [7:0] o_nv_ese,
	output logic [7:0] o_nv_sre,
	output logic o_err_clear,
	output logic o_event_summary,
	output logic [7:0] o_sre_used
);
	// Load strobe for the stored image, one cycle after release
	logic load_ff;
	// Whether the load has already happened
	logic loaded_ff;
	// Standard Event enable register
	logic [7:0] std_event_enable_ff;
	// Status Byte enable register
	logic [7:0] sre_ff;
	// Standard Event register
	logic [7:0] event_ff;
	// Next value of the event register
	logic [7:0] nxt_event;
	// Response registers
	logic rsp_valid_ff;
	sesc_pkg::sesc_rsp_t rsp_ff;
	// Error queue clear pulse
	logic err_clr_ff;
	// Summary bit
	logic summary_ff;
	// Nonvolatile write-back strobe for enables
	logic en_we_ff;
	// Decoded setting write strobe
	logic psc_wr;
	// Live power-on clear flag from the flag store
	logic psc_live;
	// One-cycle power-up decision strobe
	logic restore;
	// Write-back request raised by a setting change
	logic psc_we;

	// Setting write decoded once and shared with the flag store
	assign psc_wr = i_req_valid && (i_req.cmd == sesc_pkg::SESC_CMD_PSC_WR);

	// Flag store and power-up restore sequencing
	sesc_nv_store u_nv
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_nv_psc(i_nv_psc),
		.i_nv_ese(i_nv_ese),
		.i_nv_sre(i_nv_sre),
		.i_load(load_ff),
		.i_psc_wr(psc_wr),
		.i_psc_val(i_req.arg[0]),
		.o_psc(psc_live),
		.o_restore(restore),
		.o_nv_we(psc_we)
	);

	// Single load strobe; a strap-like input is taken after release
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			load_ff <= 1'b0;
			loaded_ff <= 1'b0;
		end
		else
		begin
			load_ff <= !loaded_ff;
			loaded_ff <= 1'b1;
		end
	end

	// Event enable: power-up decision, then command writes
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			std_event_enable_ff <= sesc_pkg::SESC_ZERO8;
		else if (restore)
		begin
			if (psc_live)
				std_event_enable_ff <= sesc_pkg::SESC_ZERO8;
			else
				std_event_enable_ff <= i_nv_ese;
		end
		else if (i_req_valid && i_req.cmd == sesc_pkg::SESC_CMD_ESE_WR)
			std_event_enable_ff <= i_req.arg;
	end

	// Status byte enable follows the same power-up choice
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			sre_ff <= sesc_pkg::SESC_ZERO8;
		else if (restore)
		begin
			if (psc_live)
				sre_ff <= sesc_pkg::SESC_ZERO8;
			else
				sre_ff <= i_nv_sre;
		end
		else if (i_req_valid && i_req.cmd == sesc_pkg::SESC_CMD_SRE_WR)
			sre_ff <= i_req.arg;
		else if (i_req_valid && i_req.cmd == sesc_pkg::SESC_CMD_CLS)
			sre_ff <= sre_ff;
	end

	// Event register next value; hardware sets win over clears
	always_comb
	begin
		nxt_event = event_ff;
		if (i_req_valid && (i_req.cmd == sesc_pkg::SESC_CMD_CLS
			|| i_req.cmd == sesc_pkg::SESC_CMD_ESR_RD))
			nxt_event = sesc_pkg::SESC_ZERO8;
		nxt_event = nxt_event | i_event_set;
		if (i_req_valid && i_req.cmd == sesc_pkg::SESC_CMD_OPC)
			nxt_event[sesc_pkg::SESC_OPC_BIT] = 1'b1;
	end

	// Event register update
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			event_ff <= sesc_pkg::SESC_ZERO8;
		else
			event_ff <= nxt_event;
	end

	// Summary uses only functional enable bits; spare bits stay silent
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			summary_ff <= 1'b0;
		else
			summary_ff <= |(event_ff & std_event_enable_ff
				& sesc_pkg::SESC_ESE_USED);
	end

	// Query answers, one cycle after the request
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_ff <= '0;
		end
		else
		begin
			rsp_valid_ff <= 1'b0;
			if (i_req_valid)
			begin
				case (i_req.cmd)
					sesc_pkg::SESC_CMD_ESE_RD:
					begin
						// Spare bits read back as written
						rsp_valid_ff <= 1'b1;
						rsp_ff <= {1'b0, std_event_enable_ff};
					end
					sesc_pkg::SESC_CMD_ESR_RD:
					begin
						// Value before the clear of this same read
						rsp_valid_ff <= 1'b1;
						rsp_ff <= {1'b0, event_ff};
					end
					sesc_pkg::SESC_CMD_OPC_RD:
					begin
						rsp_valid_ff <= 1'b1;
						rsp_ff <= {1'b1, sesc_pkg::SESC_CHAR_ONE};
					end
					sesc_pkg::SESC_CMD_PSC_RD:
					begin
						rsp_valid_ff <= 1'b1;
						rsp_ff <= {1'b0, sesc_pkg::SESC_ZERO8[7:1],
							psc_live};
					end
					sesc_pkg::SESC_CMD_SRE_RD:
					begin
						rsp_valid_ff <= 1'b1;
						rsp_ff <= {1'b0, sre_ff};
					end
					default:
						rsp_valid_ff <= 1'b0;
				endcase
			end
		end
	end

	// Clear-status also empties the error queue held elsewhere
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			err_clr_ff <= 1'b0;
		else
			err_clr_ff <= i_req_valid
				&& i_req.cmd == sesc_pkg::SESC_CMD_CLS;
	end

	// Enables are saved on change so setting 0 can restore them
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			en_we_ff <= 1'b0;
		else
			en_we_ff <= i_req_valid
				&& (i_req.cmd == sesc_pkg::SESC_CMD_ESE_WR
				|| i_req.cmd == sesc_pkg::SESC_CMD_SRE_WR);
	end

	// Outputs come straight from flip-flops, except o_nv_we (an OR of two strobes); the masked view is an AND
	assign o_rsp_valid = rsp_valid_ff;
	assign o_rsp = rsp_ff;
	assign o_nv_we = psc_we | en_we_ff;
	assign o_nv_psc = psc_live;
	assign o_nv_ese = std_event_enable_ff;
	assign o_nv_sre = sre_ff;
	assign o_err_clear = err_clr_ff;
	assign o_event_summary = summary_ff;
	assign o_sre_used = sre_ff & sesc_pkg::SESC_SRE_USED;
endmodule

// *** dv/sesc_top_sva.sv ***
`timescale 1ns/100ps
// Ties each answer to a query, and the error-clear and enable-write write-back strobes to their commands
module sesc_top_sva
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire sesc_pkg::sesc_req_t i_req,
	input wire logic [7:0] i_event_set,
	input wire logic o_rsp_valid,
	input wire sesc_pkg::sesc_rsp_t o_rsp,
	input wire logic o_nv_we,
	input wire logic [7:0] o_nv_ese,
	input wire logic o_err_clear
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Taken command, zero when idle
	wire [3:0] cmd = i_req_valid ? i_req.cmd : 4'h0;
	// Query codes: ESE_RD, ESR_RD, OPC_RD, PSC_RD, SRE_RD
	wire qry = cmd inside {4'h2, 4'h3, 4'h5, 4'h7, 4'hA};
	ese_load_a: assert property (
		cmd == 4'h1 |=> o_nv_ese == $past(i_req.arg))
		else $error("enable write not loaded");
	ese_back_a: assert property (
		cmd == 4'h2 |=> o_rsp_valid
		&& o_rsp == {1'b0, $past(o_nv_ese)})
		else $error("enable query wrong");
	rsp_cause_a: assert property (
		o_rsp_valid |-> $past(qry))
		else $error("answer without query");
	opc_set_a: assert property (
		cmd == 4'h4 ##1 cmd == 4'h3 |=> o_rsp.value[0])
		else $error("completion bit not set");
	opc_char_a: assert property (
		cmd == 4'h5 |=> o_rsp_valid && o_rsp == 9'h131)
		else $error("completion char wrong");
	ese_save_a: assert property (
		cmd == 4'h1 && i_req.arg != o_nv_ese |=> o_nv_we)
		else $error("no store write-back");
	cls_err_a: assert property (
		cmd == 4'h8 |=> o_err_clear)
		else $error("error clear missing");
	esr_clr_a: assert property (
		cmd == 4'h3 && i_event_set == 8'h00
		##1 cmd == 4'h3 && i_event_set == 8'h00
		|=> o_rsp.value == 8'h00)
		else $error("event reg not cleared");
endmodule
bind sesc_top sesc_top_sva i_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_req_valid(i_req_valid), .i_req(i_req), .i_event_set(i_event_set),
	.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_nv_we(o_nv_we),
	.o_nv_ese(o_nv_ese), .o_err_clear(o_err_clear));

// *** dv/sesc_nv_model.sv ***
`timescale 1ns/100ps
// Store beside the block; no reset, so contents outlive a power cycle
module sesc_nv_model
(
	input wire logic i_ref_clk,
	input wire logic i_we,
	input wire logic [16:0] i_img,
	output logic [16:0] o_img
);
	// Blank store at first power-up; one process owns the image
	logic [16:0] img_ff = 17'h00000;
	// Whole image taken on each write-back
	always @(posedge i_ref_clk)
		if (i_we)
			img_ff <= i_img;
	assign o_img = img_ff;
endmodule

// *** dv/sesc_top_bench.sv ***
`timescale 1ns/100ps
// Commands one a cycle; checks answers, events and power cycles
module sesc_top_bench;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_req_valid = 1'b0;
	sesc_pkg::sesc_req_t i_req = '0;
	logic [7:0] i_event_set = 8'h00;
	logic i_nv_psc, o_rsp_valid, o_nv_we, o_nv_psc, o_err_clear;
	logic o_event_summary;
	logic [7:0] i_nv_ese, i_nv_sre, o_nv_ese, o_nv_sre, o_sre_used;
	sesc_pkg::sesc_rsp_t o_rsp;
	logic [16:0] nv_img;
	int miscompares = 0;
	int checked = 0;
	logic [7:0] wv [3] = '{8'hA0, 8'hFF, 8'h00};
	sesc_top i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_req_valid(i_req_valid), .i_req(i_req), .i_event_set(i_event_set),
		.i_nv_psc(i_nv_psc), .i_nv_ese(i_nv_ese), .i_nv_sre(i_nv_sre),
		.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_nv_we(o_nv_we),
		.o_nv_psc(o_nv_psc), .o_nv_ese(o_nv_ese), .o_nv_sre(o_nv_sre),
		.o_err_clear(o_err_clear), .o_event_summary(o_event_summary),
		.o_sre_used(o_sre_used));
	sesc_nv_model i_nv (.i_ref_clk(i_ref_clk), .i_we(o_nv_we),
		.i_img({o_nv_psc, o_nv_ese, o_nv_sre}), .o_img(nv_img));
	assign {i_nv_psc, i_nv_ese, i_nv_sre} = nv_img;
	// 50 MHz
	initial forever #10 i_ref_clk = ~i_ref_clk;
	task chk(input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// Strobe stays up so calls in a row are back to back
	task rq(input logic [3:0] c, input logic [7:0] a);
		@(posedge i_ref_clk);
		#1;
		i_req_valid = 1'b1;
		i_req = {c, a};
		i_event_set = 8'h00;
	endtask
	task ev(input logic [7:0] v);
		@(posedge i_ref_clk);
		#1;
		i_req_valid = 1'b0;
		i_event_set = v;
	endtask
	task idle();
		ev(8'h00);
	endtask
	// Answer stands only in the cycle after the taking edge
	task q(input logic [3:0] c, input logic [8:0] exp);
		rq(c, 8'h00);
		idle();
		chk({8'h00, o_rsp_valid}, 9'h001);
		chk(o_rsp, exp);
	endtask
	// Restore takes effect on the third edge, so requests wait three
	task pwr();
		i_rst = 1'b1;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_rst = 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask
	task tally_and_finish();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		pwr();
		for (int k = 0; k < 3; k++)
		begin
			rq(4'h1, wv[k]);
			q(4'h2, {1'b0, wv[k]});
		end
		// Only loose bits enabled: events there must stay silent
		rq(4'h1, 8'h42);
		ev(8'h42);
		idle();
		idle();
		chk({8'h00, o_event_summary}, 9'h000);
		rq(4'h1, 8'h80);
		ev(8'h80);
		idle();
		idle();
		chk({8'h00, o_event_summary}, 9'h001);
		rq(4'h3, 8'h00);
		rq(4'h3, 8'h00);
		chk(o_rsp, 9'h0C2);
		idle();
		chk(o_rsp, 9'h000);
		rq(4'h4, 8'h00);
		q(4'h3, 9'h001);
		q(4'h5, 9'h131);
		// Event pending when status is cleared
		ev(8'h20);
		rq(4'h8, 8'h00);
		idle();
		chk({8'h00, o_err_clear}, 9'h001);
		q(4'h3, 9'h000);
		rq(4'hF, 8'h00);
		idle();
		chk({8'h00, o_rsp_valid}, 9'h000);
		rq(4'h1, 8'hA0);
		rq(4'h9, 8'h30);
		rq(4'h6, 8'h00);
		idle();
		idle();
		q(4'h7, 9'h000);
		pwr();
		q(4'h2, 9'h0A0);
		q(4'hA, 9'h030);
		rq(4'h6, 8'h01);
		idle();
		idle();
		q(4'h7, 9'h001);
		pwr();
		q(4'h2, 9'h000);
		q(4'hA, 9'h000);
		q(4'h7, 9'h001);
		// Spare status byte enable bits read back but are masked out
		rq(4'h9, 8'hFF);
		idle();
		chk({1'b0, o_sre_used}, 9'h038);
		q(4'hA, 9'h0FF);
		tally_and_finish();
	end
	// Tests need about 80 cycles
	initial
	begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
endmodule
